/* fbs_io_image.sv */
// Purpose: cyclic input/output image of a fieldbus slave motion unit
// Assumes: one clock; pins synchronised here, status from same-clock logic
// Notes:   master reads a snapshot on poll, output words go to user variables
`timescale 1ns/1ps

// How it works
// - size switch off gives two words each way, on gives four.
// - a short image sits in the least significant bits of its word.
// - status bit 0 is high while the unit runs.
// - status bit 1 is high while the servo driver is enabled.
// - status bit 2 is high while axis 0 is servo-on in closed loop.
// - status bit 3 is high while any axis has a motion error.
// - status bit 4 is high while axis 0 exceeds its following-error warning.
// - status bits 5 and 6 mirror driver alarm and driver warning.
// - status bit 7 is high when the driver link has failed.
// - status bits 8 and 9 show axis 0 forward and reverse limits.
// - status bit 10 is high during an axis 0 origin search.
// - status bit 11 is high while the axis 0 hold input is active.
// - status bit 12 is high when axis 0 following error hits its limit.
// - status bits 13 to 15 show programs running on tasks 1 to 3.
// - input word 2 content follows the word-2 source selection.
// - input words 3 and 4 come from user variables 2 and 3, large mode only.
// - output words 1 to 4 store into user variables 1, 4, 5, 6.
module fbs_io_image
  import fbs_pkg::*;
#(
  parameter int unsigned AXES  = 2,
  parameter int unsigned TASKS = 3
) (
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  // asynchronous pins
  input  wire logic                  size_switch_i,
  input  wire logic                  driver_alarm_input_i,
  input  wire logic                  driver_warn_input_i,
  input  wire logic                  fwd_limit_i,
  input  wire logic                  rev_limit_i,
  input  wire logic                  hold_input_i,
  // unit state from same-clock logic
  input  wire logic                  unit_running_i,
  input  wire logic                  driver_enabled_i,
  input  wire logic                  axis0_closed_loop_i,
  input  wire logic [AXES-1:0]       motion_error_i,
  input  wire logic                  fe_warning_i,
  input  wire logic                  driver_comm_fail_i,
  input  wire logic                  origin_search_i,
  input  wire logic                  fe_limit_i,
  input  wire logic [TASKS-1:0]      task_running_i,
  // word-2 sources
  input  wire logic [1:0]            word2_source_select_i,
  input  wire logic [UNIT_IO_W-1:0]  unit_io_map_i,
  input  wire logic [WORD_W-1:0]     driver_io_map_i,
  // user variable memory read values
  input  wire logic [WORD_W-1:0]     uv_word2_i,
  input  wire logic [WORD_W-1:0]     uv_in_a_i,
  input  wire logic [WORD_W-1:0]     uv_in_b_i,
  // cyclic read by the master
  input  wire logic                  poll_i,
  output logic      [WORD_W-1:0]     unit_status_word_o,
  output logic      [WORD_W-1:0]     selectable_input_word_o,
  output logic      [WORD_W-1:0]     user_input_word_a_o,
  output logic      [WORD_W-1:0]     user_input_word_b_o,
  output logic      [2:0]            image_words_o,
  output logic                       image_valid_o,
  // cyclic write by the master
  input  wire logic                  out_valid_i,
  input  wire logic [WORD_W-1:0]     out_word1_i,
  input  wire logic [WORD_W-1:0]     out_word2_i,
  input  wire logic [WORD_W-1:0]     out_word3_i,
  input  wire logic [WORD_W-1:0]     out_word4_i,
  output logic                       out_ready_o,
  // user variable memory write port
  output logic                       user_variable_memory_wr_o,
  output logic      [UV_IDX_W-1:0]   user_variable_memory_idx_o,
  output logic      [WORD_W-1:0]     user_variable_memory_data_o
);

  // write sequencer states
  // idle: ready high, a master write is taken on any edge with out_valid_i
  // store: one word per cycle into user variables, new writes refused
  typedef enum logic [0:0] {
    FBS_IDLE,
    FBS_STORE
  } fbs_state_t;

  typedef struct packed {
    fbs_state_t                  state;
    logic [WORD_W-1:0]           status;
    logic [WORD_W-1:0]           sel;
    logic [WORD_W-1:0]           in_a;
    logic [WORD_W-1:0]           in_b;
    logic [2:0]                  words;
    logic                        img_valid;
    logic                        out_ready;
    logic [3:0][WORD_W-1:0]      obuf;
    logic [1:0]                  pos;
    logic [1:0]                  last;
    logic                        uv_wr;
    logic [UV_IDX_W-1:0]         uv_idx;
    logic [WORD_W-1:0]           uv_data;
  } fbs_img_t;

  fbs_img_t st_reg;
  fbs_img_t st_next;

  // pin levels come out three to four edges behind the pins
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_lvl;
  logic [WORD_W-1:0]    status_now;
  logic [WORD_W-1:0]    sel_now;
  logic                 large_mode;

  // external pins cross into the clock domain here
  // bit order follows the PIN_ indices of the package
  assign pin_raw[PIN_SIZE]  = size_switch_i;
  assign pin_raw[PIN_ALARM] = driver_alarm_input_i;
  assign pin_raw[PIN_WARN]  = driver_warn_input_i;
  assign pin_raw[PIN_FWD]   = fwd_limit_i;
  assign pin_raw[PIN_REV]   = rev_limit_i;
  assign pin_raw[PIN_HOLD]  = hold_input_i;

  fbs_pin_sync #(
    .WIDTH   (PIN_COUNT)
  ) u_pin_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (pin_raw),
    .level_o (pin_lvl)
  );

  assign large_mode = pin_lvl[PIN_SIZE];
  // the switch counts once per transfer: a poll latches it with the words,
  // a write latches its last word index, so a flip in mid-store never
  // cuts or extends a write already taken

  // live status word, assembled from current levels
  // same-clock flags need no synchroniser, pin flags come through it
  always_comb begin
    status_now = WORD_ZERO;
    status_now[BIT_RUNNING]   = unit_running_i;
    status_now[BIT_DRV_EN]    = driver_enabled_i;
    status_now[BIT_SERVO_ON]  = axis0_closed_loop_i;
    status_now[BIT_MOT_ERR]   = |motion_error_i;
    status_now[BIT_FE_WARN]   = fe_warning_i;
    status_now[BIT_DRV_ALARM] = pin_lvl[PIN_ALARM];
    status_now[BIT_DRV_WARN]  = pin_lvl[PIN_WARN];
    status_now[BIT_COMM_FAIL] = driver_comm_fail_i;
    status_now[BIT_FWD_LIM]   = pin_lvl[PIN_FWD];
    status_now[BIT_REV_LIM]   = pin_lvl[PIN_REV];
    status_now[BIT_ORIGIN]    = origin_search_i;
    status_now[BIT_HOLD]      = pin_lvl[PIN_HOLD];
    status_now[BIT_FE_LIMIT]  = fe_limit_i;
    for (int t = 0; t < TASKS; t++) begin
      // tasks beyond the top bit have no flag and are dropped
      if (BIT_TASK1 + t < WORD_W) begin
        status_now[BIT_TASK1 + t] = task_running_i[t];
      end
    end
  end

  // word-2 source mux; unknown codes read zero
  always_comb begin
    case (word2_source_select_i)
      SRC_USER: begin
        sel_now = uv_word2_i;
      end
      SRC_UNIT: begin
        sel_now = {{(WORD_W - UNIT_IO_W){1'b0}}, unit_io_map_i};
      end
      SRC_DRIVER: begin
        sel_now = driver_io_map_i;
      end
      default: begin
        sel_now = WORD_ZERO;
      end
    endcase
  end

  // read timing: edge 0 samples poll_i high, edge 1 shows image_valid_o
  // together with all four words; the words then stand until the next poll
  // and back-to-back polls each give a pulse
  // write timing, small image: edge 0 takes out_valid_i, edge 1 drops
  // out_ready_o, edges 2 and 3 store words 1 and 2 and raise ready again
  // with the last store; the next write can already be taken on that same edge 3
  // large image: words 3 and 4 follow on edges 4 and 5, ready with the last
  // trade-off: all four words are buffered at the taking edge, so the
  // master may change its words at once, at the cost of a 64-bit buffer
  // snapshot on poll, output word store sequence
  always_comb begin
    st_next           = st_reg;
    // both strobes are one-cycle pulses, cleared unless set below
    st_next.img_valid = 1'b0;
    st_next.uv_wr     = 1'b0;

    // a poll during a store is served at once, the two sides share no state
    // one-cycle coherent snapshot
    if (poll_i) begin
      st_next.status    = status_now;
      st_next.sel       = sel_now;
      st_next.img_valid = 1'b1;
      // extra words only in large mode
      if (large_mode) begin
        st_next.in_a  = uv_in_a_i;
        st_next.in_b  = uv_in_b_i;
        st_next.words = WORDS_LARGE;
      end else begin
        st_next.in_a  = WORD_ZERO;
        st_next.in_b  = WORD_ZERO;
        st_next.words = WORDS_SMALL;
      end
    end

    case (st_reg.state)
      FBS_IDLE: begin
        // writes arriving while busy are refused through out_ready_o
        // words are copied whole so a later change cannot tear the image
        if (out_valid_i) begin
          st_next.obuf      = {out_word4_i, out_word3_i, out_word2_i, out_word1_i};
          st_next.pos       = 2'h0;
          st_next.last      = large_mode ? 2'(WORDS_LARGE - 3'h1) : 2'(WORDS_SMALL - 3'h1);
          st_next.out_ready = 1'b0;
          st_next.state     = FBS_STORE;
        end
      end
      FBS_STORE: begin
        // word to user variable
        // pos walks the buffer; last was fixed when the write was taken
        st_next.uv_wr   = 1'b1;
        st_next.uv_data = st_reg.obuf[st_reg.pos];
        case (st_reg.pos)
          2'h0: begin
            st_next.uv_idx = UV_OUT1;
          end
          2'h1: begin
            st_next.uv_idx = UV_OUT2;
          end
          2'h2: begin
            st_next.uv_idx = UV_OUT3;
          end
          default: begin
            st_next.uv_idx = UV_OUT4;
          end
        endcase
        if (st_reg.pos == st_reg.last) begin
          st_next.out_ready = 1'b1;
          st_next.state     = FBS_IDLE;
        end else begin
          st_next.pos = st_reg.pos + 2'h1;
        end
      end
      default: begin
        // an illegal state recovers to idle with the write side ready
        st_next.state     = FBS_IDLE;
        st_next.out_ready = 1'b1;
      end
    endcase
  end

  // single state register; reset leaves an empty small image and a ready
  // write side: the struct is cleared, then the few non-zero fields set
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_reg           <= '0;
      st_reg.state     <= FBS_IDLE;
      st_reg.words     <= WORDS_SMALL;
      st_reg.out_ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  // read side
  assign unit_status_word_o          = st_reg.status;
  assign selectable_input_word_o     = st_reg.sel;
  assign user_input_word_a_o         = st_reg.in_a;
  assign user_input_word_b_o         = st_reg.in_b;
  assign image_words_o               = st_reg.words;
  assign image_valid_o               = st_reg.img_valid;
  // write side
  assign out_ready_o                 = st_reg.out_ready;
  assign user_variable_memory_wr_o   = st_reg.uv_wr;
  assign user_variable_memory_idx_o  = st_reg.uv_idx;
  assign user_variable_memory_data_o = st_reg.uv_data;

endmodule : fbs_io_image

/* fbs_pkg.sv */
// Purpose: shared constants for the fieldbus slave cyclic i/o image
// Assumes: 16-bit image words, user variables addressed by a small index
// Notes:   bit positions of the unit status word and variable indices live here
package fbs_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned UV_IDX_W = 3;

  // image sizes in words per direction
  localparam logic [2:0] WORDS_SMALL = 3'h2;
  localparam logic [2:0] WORDS_LARGE = 3'h4;

  // unit status word bit positions
  localparam int unsigned BIT_RUNNING   = 0;
  localparam int unsigned BIT_DRV_EN    = 1;
  localparam int unsigned BIT_SERVO_ON  = 2;
  localparam int unsigned BIT_MOT_ERR   = 3;
  localparam int unsigned BIT_FE_WARN   = 4;
  localparam int unsigned BIT_DRV_ALARM = 5;
  localparam int unsigned BIT_DRV_WARN  = 6;
  localparam int unsigned BIT_COMM_FAIL = 7;
  localparam int unsigned BIT_FWD_LIM   = 8;
  localparam int unsigned BIT_REV_LIM   = 9;
  localparam int unsigned BIT_ORIGIN    = 10;
  localparam int unsigned BIT_HOLD      = 11;
  localparam int unsigned BIT_FE_LIMIT  = 12;
  localparam int unsigned BIT_TASK1     = 13;

  // word-2 source selection codes
  localparam logic [1:0] SRC_USER   = 2'h0;
  localparam logic [1:0] SRC_UNIT   = 2'h1;
  localparam logic [1:0] SRC_DRIVER = 2'h2;
  localparam int unsigned UNIT_IO_W = 14;

  // user variable targets of output words 1 to 4
  localparam logic [UV_IDX_W-1:0] UV_OUT1 = 3'h1;
  localparam logic [UV_IDX_W-1:0] UV_OUT2 = 3'h4;
  localparam logic [UV_IDX_W-1:0] UV_OUT3 = 3'h5;
  localparam logic [UV_IDX_W-1:0] UV_OUT4 = 3'h6;

  // pin group order into the synchroniser
  localparam int unsigned PIN_SIZE  = 0;
  localparam int unsigned PIN_ALARM = 1;
  localparam int unsigned PIN_WARN  = 2;
  localparam int unsigned PIN_FWD   = 3;
  localparam int unsigned PIN_REV   = 4;
  localparam int unsigned PIN_HOLD  = 5;
  localparam int unsigned PIN_COUNT = 6;

  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

endpackage : fbs_pkg

/* fbs_pin_sync.sv */
// Purpose: three-stage synchroniser with agreement filter for slow pins
// Assumes: pins are levels that change far slower than the clock
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module fbs_pin_sync #(
  parameter int unsigned WIDTH = 6
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  // raw pins and clean levels
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } fbs_sync_t;

  fbs_sync_t st_reg;
  fbs_sync_t st_next;

  // shift chain; a bit only moves once stages two and three agree
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.lvl[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_o = st_reg.lvl;

endmodule : fbs_pin_sync

/* fbs_io_image_assertions.sv */
// Purpose: port-level checks of the fieldbus slave image
// Assumes: one clock, synchronous reset active high
// Notes:   status flag checks fire only on a poll, so the bench must poll often
`timescale 1ns/1ps
module fbs_image_checker
  import fbs_pkg::*;
#(
  parameter int unsigned AXES  = 2,
  parameter int unsigned TASKS = 3
) (
  // clock and reset
  input wire logic              clock_i,
  input wire logic              rst_i,
  // causes of the read image
  input wire logic              poll_i,
  input wire logic              unit_running_i,
  input wire logic              driver_enabled_i,
  input wire logic [AXES-1:0]   motion_error_i,
  input wire logic [TASKS-1:0]  task_running_i,
  input wire logic [1:0]        word2_source_select_i,
  input wire logic [WORD_W-1:0] uv_word2_i,
  // read image
  input wire logic [WORD_W-1:0] unit_status_word_o,
  input wire logic [WORD_W-1:0] selectable_input_word_o,
  input wire logic [WORD_W-1:0] user_input_word_a_o,
  input wire logic [WORD_W-1:0] user_input_word_b_o,
  input wire logic [2:0]        image_words_o,
  input wire logic              image_valid_o,
  // write image
  input wire logic              out_valid_i,
  input wire logic              out_ready_o,
  input wire logic [WORD_W-1:0] out_word1_i,
  input wire logic [WORD_W-1:0] out_word2_i,
  input wire logic              user_variable_memory_wr_o,
  input wire logic [UV_IDX_W-1:0] user_variable_memory_idx_o,
  input wire logic [WORD_W-1:0] user_variable_memory_data_o
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_valid; image_valid_o == $past(poll_i); endproperty
  a_valid: assert property (p_valid) else $error("valid pulse not tied to poll");
  property p_stand; !poll_i |=> $stable(unit_status_word_o); endproperty
  a_stand: assert property (p_stand) else $error("status word moved without poll");
  property p_run; poll_i |=> unit_status_word_o[0] == $past(unit_running_i); endproperty
  a_run: assert property (p_run) else $error("running flag wrong");
  property p_drv; poll_i |=> unit_status_word_o[1] == $past(driver_enabled_i); endproperty
  a_drv: assert property (p_drv) else $error("driver enable flag wrong");
  property p_merr; poll_i |=> unit_status_word_o[3] == (|$past(motion_error_i)); endproperty
  a_merr: assert property (p_merr) else $error("motion error flag wrong");
  property p_task; poll_i |=> unit_status_word_o[15:13] == $past(task_running_i); endproperty
  a_task: assert property (p_task) else $error("task flags wrong");
  property p_w2;
    poll_i && word2_source_select_i == SRC_USER |=> selectable_input_word_o == $past(uv_word2_i);
  endproperty
  a_w2: assert property (p_w2) else $error("word 2 not from user variable");
  property p_small;
    image_valid_o && image_words_o == WORDS_SMALL |->
      user_input_word_a_o == WORD_ZERO && user_input_word_b_o == WORD_ZERO;
  endproperty
  a_small: assert property (p_small) else $error("words 3 and 4 sent in small mode");
  property p_out1;
    out_valid_i && out_ready_o |=> !out_ready_o ##1 user_variable_memory_wr_o &&
      user_variable_memory_idx_o == UV_OUT1 && user_variable_memory_data_o == $past(out_word1_i, 2);
  endproperty
  a_out1: assert property (p_out1) else $error("output word 1 not stored");
  property p_out2;
    out_valid_i && out_ready_o |-> ##3 user_variable_memory_wr_o &&
      user_variable_memory_idx_o == UV_OUT2 && user_variable_memory_data_o == $past(out_word2_i, 3);
  endproperty
  a_out2: assert property (p_out2) else $error("output word 2 not stored");
endmodule : fbs_image_checker

bind fbs_io_image fbs_image_checker #(.AXES(AXES), .TASKS(TASKS)) u_chk (.*);

/* fbs_master_model.sv */
// Purpose: behavioural fieldbus master that polls and writes the image
// Assumes: strobes change 1 ns after the rising edge
// Notes:   released words show the inverse, so stale data never looks valid
`timescale 1ns/1ps
module fbs_master_model
  import fbs_pkg::*;
(
  // clock and slave handshake
  input  wire logic         clock_i,
  input  wire logic         out_ready_i,
  // strobes and output words
  output logic              poll_o,
  output logic              out_valid_o,
  output logic [WORD_W-1:0] out_word1_o,
  output logic [WORD_W-1:0] out_word2_o,
  output logic [WORD_W-1:0] out_word3_o,
  output logic [WORD_W-1:0] out_word4_o
);
  // idle master at time zero
  initial begin
    poll_o = 1'b0;
    out_valid_o = 1'b0;
    {out_word4_o, out_word3_o, out_word2_o, out_word1_o} = '0;
  end
  task poll_image();
    @(posedge clock_i);
    #1 poll_o = 1'b1;
    @(posedge clock_i);
    #1 poll_o = 1'b0;
  endtask : poll_image
  task write_image(input logic [4*WORD_W-1:0] w);
    @(posedge clock_i);
    #1 out_valid_o = 1'b1;
    {out_word4_o, out_word3_o, out_word2_o, out_word1_o} = w;
    while (out_ready_i !== 1'b1) begin
      @(posedge clock_i);
      #1;
    end
    @(posedge clock_i);
    #1 out_valid_o = 1'b0;
    {out_word4_o, out_word3_o, out_word2_o, out_word1_o} = ~w;
  endtask : write_image
endmodule : fbs_master_model

/* tb_fieldbus_slave_io_image.sv */
// Purpose: self-checking bench for the fieldbus slave io image
// Assumes: pins settle within six clocks of a change
// Notes:   bench model rebuilds every word from the random state it drove
`timescale 1ns/1ps
module tb_fieldbus_slave_io_image;
  import fbs_pkg::*;
  // design inputs
  logic clock_i, rst_i, size_switch_i, driver_alarm_input_i, driver_warn_input_i;
  logic fwd_limit_i, rev_limit_i, hold_input_i, unit_running_i, driver_enabled_i;
  logic axis0_closed_loop_i, fe_warning_i, driver_comm_fail_i, origin_search_i, fe_limit_i;
  logic poll_i, out_valid_i;
  logic [1:0] motion_error_i, word2_source_select_i;
  logic [2:0] task_running_i;
  logic [13:0] unit_io_map_i;
  logic [15:0] driver_io_map_i, uv_word2_i, uv_in_a_i, uv_in_b_i;
  logic [15:0] out_word1_i, out_word2_i, out_word3_i, out_word4_i;
  // design outputs
  logic [15:0] unit_status_word_o, selectable_input_word_o, user_input_word_a_o;
  logic [15:0] user_input_word_b_o, user_variable_memory_data_o;
  logic [2:0] image_words_o, user_variable_memory_idx_o;
  logic image_valid_o, out_ready_o, user_variable_memory_wr_o;
  // bench state
  int seed = 11;
  int n_fail = 0;
  int n_tests = 0;
  logic [18:0] exp_q[$];
  logic [63:0] w;

  fbs_io_image uut (
    .clock_i, .rst_i, .size_switch_i, .driver_alarm_input_i, .driver_warn_input_i,
    .fwd_limit_i, .rev_limit_i, .hold_input_i, .unit_running_i, .driver_enabled_i,
    .axis0_closed_loop_i, .motion_error_i, .fe_warning_i, .driver_comm_fail_i,
    .origin_search_i, .fe_limit_i, .task_running_i, .word2_source_select_i,
    .unit_io_map_i, .driver_io_map_i, .uv_word2_i, .uv_in_a_i, .uv_in_b_i, .poll_i,
    .unit_status_word_o, .selectable_input_word_o, .user_input_word_a_o,
    .user_input_word_b_o, .image_words_o, .image_valid_o, .out_valid_i, .out_word1_i,
    .out_word2_i, .out_word3_i, .out_word4_i, .out_ready_o, .user_variable_memory_wr_o,
    .user_variable_memory_idx_o, .user_variable_memory_data_o
  );
  fbs_master_model u_master (
    .clock_i, .out_ready_i(out_ready_o), .poll_o(poll_i), .out_valid_o(out_valid_i),
    .out_word1_o(out_word1_i), .out_word2_o(out_word2_i), .out_word3_o(out_word3_i),
    .out_word4_o(out_word4_i)
  );

  // 50 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  task check(input logic [18:0] seen, input logic [18:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // new random unit state; all pins but the size switch and all flags move at once
  task rand_state();
    {driver_alarm_input_i, driver_warn_input_i, fwd_limit_i, rev_limit_i, hold_input_i,
     unit_running_i, driver_enabled_i, axis0_closed_loop_i, fe_warning_i, driver_comm_fail_i,
     origin_search_i, fe_limit_i, motion_error_i, task_running_i} = 17'($random(seed));
    {uv_word2_i, uv_in_a_i} = $random(seed);
    {uv_in_b_i, driver_io_map_i} = $random(seed);
    unit_io_map_i = 14'($random(seed));
  endtask : rand_state

  // expected unit status word from the bench's own drive
  function automatic logic [15:0] exp_status();
    return {task_running_i, fe_limit_i, hold_input_i, origin_search_i, rev_limit_i,
            fwd_limit_i, driver_comm_fail_i, driver_warn_input_i, driver_alarm_input_i,
            fe_warning_i, |motion_error_i, axis0_closed_loop_i, driver_enabled_i,
            unit_running_i};
  endfunction : exp_status

  function automatic logic [15:0] exp_w2();
    case (word2_source_select_i)
      2'h0: return uv_word2_i;
      2'h1: return {2'h0, unit_io_map_i};
      2'h2: return driver_io_map_i;
      default: return 16'h0000;
    endcase
  endfunction : exp_w2

  // stored words must match the queue in order; extras are refused writes leaking
  always @(posedge clock_i) begin
    if (user_variable_memory_wr_o === 1'b1) begin
      check(exp_q.size() != 0, 1'b1);
      if (exp_q.size() != 0)
        check({user_variable_memory_idx_o, user_variable_memory_data_o}, exp_q.pop_front());
    end
  end

  initial begin
    rst_i = 1'b1;
    size_switch_i = 1'b0;
    word2_source_select_i = 2'h0;
    rand_state();
    repeat (19) @(posedge clock_i);
    #1;
    // reset values seen while reset still holds
    check(image_words_o, WORDS_SMALL);
    check(out_ready_o, 1'b1);
    check(unit_status_word_o, 16'h0000);
    @(posedge clock_i);
    #1 rst_i = 1'b0;
    // every selection code under both sizes
    for (int i = 0; i < 48; i++) begin
      @(posedge clock_i);
      #1 rand_state();
      word2_source_select_i = i[1:0];
      size_switch_i = i[2];
      repeat (6) @(posedge clock_i);
      u_master.poll_image();
      check(image_valid_o, 1'b1);
      check(unit_status_word_o, exp_status());
      check(selectable_input_word_o, exp_w2());
      check(image_words_o, size_switch_i ? WORDS_LARGE : WORDS_SMALL);
      check(user_input_word_a_o, size_switch_i ? uv_in_a_i : 16'h0000);
      check(user_input_word_b_o, size_switch_i ? uv_in_b_i : 16'h0000);
    end
    $display("read image test done");
    // back-to-back writes: second is offered while the first is still storing
    for (int m = 0; m < 2; m++) begin
      @(posedge clock_i);
      #1 size_switch_i = m[0];
      repeat (6) @(posedge clock_i);
      for (int k = 0; k < 3; k++) begin
        w = {$random(seed), $random(seed)};
        exp_q.push_back({UV_OUT1, w[15:0]});
        exp_q.push_back({UV_OUT2, w[31:16]});
        if (m == 1) begin
          exp_q.push_back({UV_OUT3, w[47:32]});
          exp_q.push_back({UV_OUT4, w[63:48]});
        end
        u_master.write_image(w);
      end
      repeat (8) @(posedge clock_i);
      check(exp_q.size() == 0, 1'b1);
    end
    $display("write image test done");
    give_verdict();
  end

  // watchdog far beyond the roughly 500 cycles the tests need
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
endmodule : tb_fieldbus_slave_io_image
